// ---- core/nic_pci_end.sv ----
// nic end of the pci link: dma master, status target, tx and rx fifos
// How it works
// RULE_01 - all link signals act on rising clock
// RULE_02 - reset floats every pci output driver
// RULE_03 - reset releases open-drain style outputs too
// RULE_04 - reset restores all internal state defaults
// RULE_05 - host holds reset at least ten clocks
// RULE_06 - ad carries address first, then data
// RULE_07 - master drives command, then byte enables
// RULE_08 - par makes ad, cbe, par even
// RULE_09 - par lags its ad cycle by one
// RULE_10 - frame held while more data remains
// RULE_11 - frame rises for the final phase
// RULE_12 - 2k byte tx, 4k byte rx fifos
// RULE_13 - dma writes rx fifo words to host
// RULE_14 - dma reads host words into tx fifo
// RULE_15 - word moves only when irdy and trdy
// RULE_16 - no devsel in five clocks aborts
// RULE_17 - target claims with medium devsel timing
// RULE_18 - reset floats request, grant is ignored
// RULE_19 - received parity checked, mismatch flagged
`timescale 1ns/1ps
module nic_pci_end #(
  parameter int TX_WORDS = pci_pkg::TX_FIFO_BYTES / 4,
  parameter int RX_WORDS = pci_pkg::RX_FIFO_BYTES / 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pci link
  pci_link_if.dev link,
  // dma command
  input wire logic dma_start,
  input wire logic dma_tx,
  input wire logic [31:0] dma_addr,
  input wire logic [15:0] dma_words,
  output logic dma_busy,
  output logic dma_abort,
  output logic par_err,
  // transmit fifo drain
  input wire logic tx_pop,
  output logic [31:0] tx_data,
  output logic tx_dvalid,
  // receive fifo fill
  input wire logic rx_push,
  input wire logic [31:0] rx_data,
  output logic rx_full
);
  localparam int TXA = $clog2(TX_WORDS);
  localparam int RXA = $clog2(RX_WORDS);
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_REQ = 3'h1, M_ADDR = 3'h3, M_DATA = 3'h2, M_TURN = 3'h6
  } mst_e;
  typedef enum logic [1:0] {T_IDLE = 2'h0, T_DEC = 2'h1, T_DATA = 2'h3, T_TURN = 2'h2} tgt_e;

  logic [31:0] tx_mem [TX_WORDS];
  logic [31:0] rx_mem [RX_WORDS];
  logic [TXA-1:0] tx_wr_reg, tx_wr_next, tx_rd_reg, tx_rd_next;
  logic [TXA:0] tx_cnt_reg, tx_cnt_next;
  logic [RXA-1:0] rx_wr_reg, rx_wr_next, rx_rd_reg, rx_rd_next;
  logic [RXA:0] rx_cnt_reg, rx_cnt_next;
  mst_e m_reg, m_next;
  tgt_e t_reg, t_next;
  logic [31:0] addr_reg, addr_next, ad_reg, ad_next;
  logic [15:0] left_reg, left_next;
  logic [2:0] wait_reg, wait_next;
  logic dir_tx_reg, dir_tx_next, seen_reg, seen_next, abort_reg, abort_next;
  logic t_rd_reg, t_rd_next, ad_oe_reg, ad_oe_next;
  logic [3:0] cbe_reg, cbe_next;
  logic cbe_oe_reg, cbe_oe_next, frame_reg, frame_next, mctl_oe_reg, mctl_oe_next;
  logic irdy_reg, irdy_next, req_reg, req_next, req_oe_reg, req_oe_next;
  logic trdy_reg, trdy_next, devsel_reg, devsel_next, tctl_oe_reg, tctl_oe_next;
  logic par_reg, par_oe_reg, exp_reg, chk_reg, perr_reg, frame_prev_reg;
  logic tx_dv_reg, busy_reg, full_reg;
  logic [31:0] tx_q_reg;
  logic m_xfer, t_xfer, addr_seen, tx_push, rx_pop, tx_take, rx_take;

  assign m_xfer = (m_reg == M_DATA) && !irdy_reg && !link.trdy_n; // RULE_15
  assign t_xfer = (t_reg == T_DATA) && !link.irdy_n && !trdy_reg; // RULE_15
  // a falling frame that this end did not drive is someone else's address phase
  assign addr_seen = frame_prev_reg && !link.frame_n && (m_reg != M_ADDR);
  assign tx_push = m_xfer && dir_tx_reg; // RULE_14
  assign rx_pop = m_xfer && !dir_tx_reg; // RULE_13
  assign tx_take = tx_pop && (tx_cnt_reg != '0);
  assign rx_take = rx_push && !full_reg;

  // fifo pointers; dma only starts with tx room or rx data for the whole burst, so no overrun or underrun
  always_comb begin
    tx_wr_next = tx_push ? tx_wr_reg + 1'b1 : tx_wr_reg;
    tx_rd_next = tx_take ? tx_rd_reg + 1'b1 : tx_rd_reg;
    tx_cnt_next = tx_cnt_reg + (TXA+1)'(tx_push) - (TXA+1)'(tx_take);
    rx_wr_next = rx_take ? rx_wr_reg + 1'b1 : rx_wr_reg;
    rx_rd_next = rx_pop ? rx_rd_reg + 1'b1 : rx_rd_reg;
    rx_cnt_next = rx_cnt_reg + (RXA+1)'(rx_take) - (RXA+1)'(rx_pop);
  end

  always_ff @(posedge core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_reg] <= link.ad; // RULE_12
    end
    if (rx_take) begin
      rx_mem[rx_wr_reg] <= rx_data; // RULE_12
    end
    if (!rstn) begin // RULE_04
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_cnt_reg <= '0;
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_cnt_reg <= '0;
      tx_q_reg <= '0;
      tx_dv_reg <= 1'b0;
      full_reg <= 1'b0;
    end else begin
      tx_wr_reg <= tx_wr_next;
      tx_rd_reg <= tx_rd_next;
      tx_cnt_reg <= tx_cnt_next;
      rx_wr_reg <= rx_wr_next;
      rx_rd_reg <= rx_rd_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_q_reg <= tx_mem[tx_rd_reg];
      tx_dv_reg <= tx_take;
      full_reg <= (rx_cnt_next == (RXA+1)'(RX_WORDS));
    end
  end

  // bus master and target
  always_comb begin
    m_next = m_reg;
    t_next = t_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    wait_next = wait_reg;
    dir_tx_next = dir_tx_reg;
    seen_next = seen_reg;
    abort_next = 1'b0;
    t_rd_next = t_rd_reg;
    ad_next = ad_reg;
    ad_oe_next = 1'b0;
    cbe_next = cbe_reg;
    cbe_oe_next = 1'b0;
    frame_next = 1'b1;
    irdy_next = 1'b1;
    mctl_oe_next = 1'b0;
    req_next = 1'b1;
    req_oe_next = 1'b0;
    trdy_next = 1'b1;
    devsel_next = 1'b1;
    tctl_oe_next = 1'b0;
    unique case (m_reg)
      M_IDLE: begin
        if (dma_start && dma_words != '0 && (dma_tx ?
            (32'(TX_WORDS) - 32'(tx_cnt_reg) >= 32'(dma_words)) :
            (32'(rx_cnt_reg) >= 32'(dma_words)))) begin
          m_next = M_REQ;
          addr_next = {dma_addr[31:2], 2'h0};
          left_next = dma_words;
          dir_tx_next = dma_tx;
        end
      end
      M_REQ: begin
        req_next = 1'b0;
        req_oe_next = 1'b1;
        if (!link.gnt_n && link.frame_n && link.irdy_n && t_reg == T_IDLE) begin
          m_next = M_ADDR;
          req_next = 1'b1;
          frame_next = 1'b0; // RULE_10
          mctl_oe_next = 1'b1;
          ad_next = addr_reg; // RULE_06
          ad_oe_next = 1'b1;
          cbe_next = dir_tx_reg ? pci_pkg::CMD_MEM_READ : pci_pkg::CMD_MEM_WRITE; // RULE_07
          cbe_oe_next = 1'b1;
        end
      end
      M_ADDR: begin
        m_next = M_DATA;
        wait_next = 3'h1;
        seen_next = !link.devsel_n;
        frame_next = (left_reg == 16'h1); // RULE_11
        irdy_next = 1'b0;
        mctl_oe_next = 1'b1;
        ad_next = rx_mem[rx_rd_reg]; // RULE_06
        ad_oe_next = !dir_tx_reg;
        cbe_next = pci_pkg::BE_ALL; // RULE_07
        cbe_oe_next = 1'b1;
      end
      M_DATA: begin
        frame_next = frame_reg;
        irdy_next = 1'b0;
        mctl_oe_next = 1'b1;
        ad_oe_next = !dir_tx_reg;
        cbe_oe_next = 1'b1;
        seen_next = seen_reg || !link.devsel_n;
        wait_next = (wait_reg == 3'h7) ? wait_reg : wait_reg + 3'h1;
        if (m_xfer) begin
          left_next = left_reg - 16'h1;
          addr_next = addr_reg + 32'h4;
          ad_next = rx_mem[rx_rd_reg + 1'b1];
          if (left_reg == 16'h2) begin
            frame_next = 1'b1; // RULE_11
          end
        end
        if (!link.stop_n) begin
          frame_next = 1'b1;
        end
        if (!seen_reg && link.devsel_n && 32'(wait_reg) >= pci_pkg::DEVSEL_LIMIT) begin
          // frame rises a clock ahead of irdy
          m_next = frame_reg ? M_TURN : m_reg; // RULE_16
          abort_next = frame_reg;
          left_next = frame_reg ? '0 : left_reg;
          frame_next = 1'b1;
          irdy_next = frame_reg;
        end else if (frame_reg && (m_xfer || !link.stop_n)) begin
          m_next = M_TURN;
          irdy_next = 1'b1;
        end
      end
      M_TURN: begin
        mctl_oe_next = 1'b1;
        // stopped bursts resume at the next address once the bus is granted again
        m_next = (left_reg == '0) ? M_IDLE : M_REQ;
      end
      default: m_next = M_IDLE;
    endcase
    unique case (t_reg)
      T_IDLE: begin
        if (addr_seen && (link.ad - pci_pkg::NIC_BASE) < pci_pkg::NIC_SPAN &&
            (link.cbe_n == pci_pkg::CMD_MEM_READ || link.cbe_n == pci_pkg::CMD_MEM_WRITE)) begin
          t_next = T_DEC;
          t_rd_next = (link.cbe_n == pci_pkg::CMD_MEM_READ);
        end
      end
      T_DEC: begin
        t_next = T_DATA;
        devsel_next = 1'b0; // RULE_17
        trdy_next = 1'b0;
        tctl_oe_next = 1'b1;
        ad_next = {16'(tx_cnt_reg), 16'(rx_cnt_reg)};
        ad_oe_next = t_rd_reg;
      end
      T_DATA: begin
        devsel_next = 1'b0;
        trdy_next = 1'b0;
        tctl_oe_next = 1'b1;
        ad_next = {16'(tx_cnt_reg), 16'(rx_cnt_reg)};
        ad_oe_next = t_rd_reg;
        if (t_xfer && link.frame_n) begin
          t_next = T_TURN;
          devsel_next = 1'b1;
          trdy_next = 1'b1;
          ad_oe_next = 1'b0;
        end
      end
      T_TURN: begin
        tctl_oe_next = 1'b1;
        t_next = T_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin // RULE_01
    if (!rstn) begin // RULE_02 RULE_03 RULE_18
      m_reg <= M_IDLE;
      t_reg <= T_IDLE;
      addr_reg <= '0;
      left_reg <= '0;
      wait_reg <= '0;
      dir_tx_reg <= 1'b0;
      seen_reg <= 1'b0;
      abort_reg <= 1'b0;
      t_rd_reg <= 1'b0;
      ad_reg <= '0;
      ad_oe_reg <= 1'b0;
      cbe_reg <= 4'hf;
      cbe_oe_reg <= 1'b0;
      frame_reg <= 1'b1;
      irdy_reg <= 1'b1;
      mctl_oe_reg <= 1'b0;
      req_reg <= 1'b1;
      req_oe_reg <= 1'b0;
      trdy_reg <= 1'b1;
      devsel_reg <= 1'b1;
      tctl_oe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      m_reg <= m_next;
      t_reg <= t_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      wait_reg <= wait_next;
      dir_tx_reg <= dir_tx_next;
      seen_reg <= seen_next;
      abort_reg <= abort_next;
      t_rd_reg <= t_rd_next;
      ad_reg <= ad_next;
      ad_oe_reg <= ad_oe_next;
      cbe_reg <= cbe_next;
      cbe_oe_reg <= cbe_oe_next;
      frame_reg <= frame_next;
      irdy_reg <= irdy_next;
      mctl_oe_reg <= mctl_oe_next;
      req_reg <= req_next;
      req_oe_reg <= req_oe_next;
      trdy_reg <= trdy_next;
      devsel_reg <= devsel_next;
      tctl_oe_reg <= tctl_oe_next;
      busy_reg <= (m_next != M_IDLE);
    end
  end

  // parity out one clock behind ad, and check of what others drove
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      par_reg <= 1'b0;
      par_oe_reg <= 1'b0;
      exp_reg <= 1'b0;
      chk_reg <= 1'b0;
      perr_reg <= 1'b0;
      frame_prev_reg <= 1'b1;
    end else begin
      par_reg <= ^{ad_reg, link.cbe_n}; // RULE_08 RULE_09
      par_oe_reg <= ad_oe_reg; // RULE_09
      exp_reg <= ^{link.ad, link.cbe_n};
      chk_reg <= addr_seen || (m_xfer && dir_tx_reg) || (t_xfer && !t_rd_reg); // RULE_19
      perr_reg <= chk_reg && (link.par != exp_reg); // RULE_19
      frame_prev_reg <= link.frame_n;
    end
  end

  assign link.dev_ad_o = ad_reg;
  assign link.dev_ad_oe = ad_oe_reg;
  assign link.dev_cbe_o = cbe_reg;
  assign link.dev_cbe_oe = cbe_oe_reg;
  assign link.dev_par_o = par_reg;
  assign link.dev_par_oe = par_oe_reg;
  assign link.dev_frame_o = frame_reg;
  assign link.dev_frame_oe = mctl_oe_reg;
  assign link.dev_irdy_o = irdy_reg;
  assign link.dev_irdy_oe = mctl_oe_reg;
  assign link.dev_trdy_o = trdy_reg;
  assign link.dev_trdy_oe = tctl_oe_reg;
  assign link.dev_devsel_o = devsel_reg;
  assign link.dev_devsel_oe = tctl_oe_reg;
  assign link.dev_stop_o = 1'b1;
  assign link.dev_stop_oe = tctl_oe_reg;
  assign link.dev_req_o = req_reg;
  assign link.dev_req_oe = req_oe_reg;
  assign dma_busy = busy_reg;
  assign dma_abort = abort_reg;
  assign par_err = perr_reg;
  assign tx_data = tx_q_reg;
  assign tx_dvalid = tx_dv_reg;
  assign rx_full = full_reg;
endmodule : nic_pci_end

// ---- core/pci_pkg.sv ----
// shared constants of the pci host-bus link
package pci_pkg;
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] BE_ALL = 4'h0;
  localparam int TX_FIFO_BYTES = 2048;
  localparam int RX_FIFO_BYTES = 4096;
  localparam int DEVSEL_LIMIT = 5;
  localparam int RESET_HOLD_CYCLES = 10;
  localparam logic [31:0] NIC_BASE = 32'h8000_0000;
  localparam logic [31:0] NIC_SPAN = 32'h0000_0100;
  localparam logic [31:0] HOST_SPAN = 32'h0001_0000;
endpackage : pci_pkg

// ---- core/pci_link_if.sv ----
// shared pci wires between the nic end and the host end
`timescale 1ns/1ps
interface pci_link_if;
  logic [31:0] dev_ad_o, host_ad_o, ad;
  logic dev_ad_oe, host_ad_oe;
  logic [3:0] dev_cbe_o, host_cbe_o, cbe_n;
  logic dev_cbe_oe, host_cbe_oe;
  logic dev_par_o, host_par_o, dev_par_oe, host_par_oe, par;
  logic dev_frame_o, host_frame_o, dev_frame_oe, host_frame_oe, frame_n;
  logic dev_irdy_o, host_irdy_o, dev_irdy_oe, host_irdy_oe, irdy_n;
  logic dev_trdy_o, host_trdy_o, dev_trdy_oe, host_trdy_oe, trdy_n;
  logic dev_devsel_o, host_devsel_o, dev_devsel_oe, host_devsel_oe, devsel_n;
  logic dev_stop_o, host_stop_o, dev_stop_oe, host_stop_oe, stop_n;
  logic dev_req_o, dev_req_oe, req_n;
  logic host_gnt_o, gnt_n;
  // undriven lines read high, as with bus pull-ups
  assign ad = dev_ad_oe ? dev_ad_o : host_ad_oe ? host_ad_o : 32'hffff_ffff;
  assign cbe_n = dev_cbe_oe ? dev_cbe_o : host_cbe_oe ? host_cbe_o : 4'hf;
  assign par = dev_par_oe ? dev_par_o : host_par_oe ? host_par_o : 1'b1;
  assign frame_n = dev_frame_oe ? dev_frame_o : host_frame_oe ? host_frame_o : 1'b1;
  assign irdy_n = dev_irdy_oe ? dev_irdy_o : host_irdy_oe ? host_irdy_o : 1'b1;
  assign trdy_n = dev_trdy_oe ? dev_trdy_o : host_trdy_oe ? host_trdy_o : 1'b1;
  assign devsel_n = dev_devsel_oe ? dev_devsel_o : host_devsel_oe ? host_devsel_o : 1'b1;
  assign stop_n = dev_stop_oe ? dev_stop_o : host_stop_oe ? host_stop_o : 1'b1;
  assign req_n = dev_req_oe ? dev_req_o : 1'b1;
  assign gnt_n = host_gnt_o;
  modport dev (
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe,
    output dev_frame_o, dev_frame_oe, dev_irdy_o, dev_irdy_oe, dev_trdy_o, dev_trdy_oe,
    output dev_devsel_o, dev_devsel_oe, dev_stop_o, dev_stop_oe, dev_req_o, dev_req_oe,
    input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, gnt_n
  );
  modport host (
    output host_ad_o, host_ad_oe, host_cbe_o, host_cbe_oe, host_par_o, host_par_oe,
    output host_frame_o, host_frame_oe, host_irdy_o, host_irdy_oe,
    output host_trdy_o, host_trdy_oe, host_devsel_o, host_devsel_oe,
    output host_stop_o, host_stop_oe, host_gnt_o,
    input ad, cbe_n, par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, req_n
  );
endinterface : pci_link_if

// ---- core/host_pci_end.sv ----
// host end of the pci link: arbiter, memory target, single-word master
`timescale 1ns/1ps
module host_pci_end #(
  parameter int MEM_WORDS = 1024
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // pci link
  pci_link_if.host link,
  // single-word master command
  input wire logic hm_start,
  input wire logic hm_write,
  input wire logic [31:0] hm_addr,
  input wire logic [31:0] hm_wdata,
  output logic hm_busy,
  output logic hm_done,
  output logic hm_abort,
  output logic [31:0] hm_rdata,
  output logic par_err
);
  localparam int MA = $clog2(MEM_WORDS);
  typedef enum logic [1:0] {H_IDLE = 2'h0, H_ADDR = 2'h1, H_DATA = 2'h3, H_TURN = 2'h2} hst_e;
  typedef enum logic [1:0] {S_IDLE = 2'h0, S_DEC = 2'h1, S_DATA = 2'h3, S_TURN = 2'h2} slv_e;
  logic [31:0] mem [MEM_WORDS];
  hst_e h_reg, h_next;
  slv_e s_reg, s_next;
  logic [MA-1:0] idx_reg, idx_next;
  logic [31:0] ad_reg, ad_next, rdata_reg, rdata_next;
  logic [3:0] cbe_reg, cbe_next;
  logic [2:0] wait_reg, wait_next;
  logic ad_oe_reg, ad_oe_next, cbe_oe_reg, cbe_oe_next, frame_reg, frame_next;
  logic irdy_reg, irdy_next, mctl_oe_reg, mctl_oe_next, trdy_reg, trdy_next;
  logic devsel_reg, devsel_next, tctl_oe_reg, tctl_oe_next, s_rd_reg, s_rd_next;
  logic gnt_reg, gnt_next, done_reg, done_next, abort_reg, abort_next, seen_reg, seen_next;
  logic par_reg, par_oe_reg, exp_reg, chk_reg, perr_reg, frame_prev_reg, busy_reg;
  logic h_xfer, s_xfer, addr_seen, bus_idle;

  assign h_xfer = (h_reg == H_DATA) && !irdy_reg && !link.trdy_n;
  assign s_xfer = (s_reg == S_DATA) && !link.irdy_n && !trdy_reg;
  assign addr_seen = frame_prev_reg && !link.frame_n && (h_reg != H_ADDR);
  assign bus_idle = link.frame_n && link.irdy_n;

  always_comb begin
    h_next = h_reg;
    s_next = s_reg;
    idx_next = idx_reg;
    ad_next = ad_reg;
    rdata_next = rdata_reg;
    cbe_next = cbe_reg;
    wait_next = wait_reg;
    seen_next = seen_reg;
    s_rd_next = s_rd_reg;
    ad_oe_next = 1'b0;
    cbe_oe_next = 1'b0;
    frame_next = 1'b1;
    irdy_next = 1'b1;
    mctl_oe_next = 1'b0;
    trdy_next = 1'b1;
    devsel_next = 1'b1;
    tctl_oe_next = 1'b0;
    done_next = 1'b0;
    abort_next = 1'b0;
    // grant goes to the nic only while it requests and the host master is idle and not starting
    gnt_next = !(!link.req_n && h_reg == H_IDLE && !hm_start);
    unique case (h_reg)
      H_IDLE: begin
        if (hm_start && gnt_reg && link.req_n && bus_idle && s_reg == S_IDLE) begin
          h_next = H_ADDR;
          frame_next = 1'b0;
          mctl_oe_next = 1'b1;
          ad_next = {hm_addr[31:2], 2'h0};
          ad_oe_next = 1'b1;
          cbe_next = hm_write ? pci_pkg::CMD_MEM_WRITE : pci_pkg::CMD_MEM_READ;
          cbe_oe_next = 1'b1;
        end
      end
      H_ADDR: begin
        h_next = H_DATA;
        wait_next = 3'h1;
        seen_next = !link.devsel_n;
        irdy_next = 1'b0;
        mctl_oe_next = 1'b1;
        ad_next = hm_wdata;
        ad_oe_next = (cbe_reg == pci_pkg::CMD_MEM_WRITE);
        cbe_next = pci_pkg::BE_ALL;
        cbe_oe_next = 1'b1;
      end
      H_DATA: begin
        irdy_next = 1'b0;
        mctl_oe_next = 1'b1;
        ad_oe_next = ad_oe_reg;
        cbe_oe_next = 1'b1;
        seen_next = seen_reg || !link.devsel_n;
        wait_next = (wait_reg == 3'h7) ? wait_reg : wait_reg + 3'h1;
        if (h_xfer) begin
          h_next = H_TURN;
          irdy_next = 1'b1;
          done_next = 1'b1;
          rdata_next = link.ad;
        end else if (!link.stop_n ||
            (!seen_reg && link.devsel_n && 32'(wait_reg) >= pci_pkg::DEVSEL_LIMIT)) begin
          h_next = H_TURN;
          irdy_next = 1'b1;
          abort_next = 1'b1;
        end
      end
      H_TURN: begin
        mctl_oe_next = 1'b1;
        h_next = H_IDLE;
      end
    endcase
    unique case (s_reg)
      S_IDLE: begin
        if (addr_seen && link.ad < pci_pkg::HOST_SPAN &&
            (link.cbe_n == pci_pkg::CMD_MEM_READ || link.cbe_n == pci_pkg::CMD_MEM_WRITE)) begin
          s_next = S_DEC;
          s_rd_next = (link.cbe_n == pci_pkg::CMD_MEM_READ);
          idx_next = link.ad[MA+1:2];
        end
      end
      S_DEC, S_DATA: begin
        s_next = S_DATA;
        devsel_next = 1'b0;
        trdy_next = 1'b0;
        tctl_oe_next = 1'b1;
        ad_oe_next = s_rd_reg;
        ad_next = mem[idx_reg];
        if (s_xfer) begin
          idx_next = idx_reg + 1'b1;
          ad_next = mem[idx_reg + 1'b1];
          if (link.frame_n) begin
            s_next = S_TURN;
            devsel_next = 1'b1;
            trdy_next = 1'b1;
            ad_oe_next = 1'b0;
          end
        end
      end
      S_TURN: begin
        tctl_oe_next = 1'b1;
        s_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (s_xfer && !s_rd_reg) begin
      mem[idx_reg] <= link.ad;
    end
    if (!rstn) begin
      h_reg <= H_IDLE;
      s_reg <= S_IDLE;
      idx_reg <= '0;
      ad_reg <= '0;
      rdata_reg <= '0;
      cbe_reg <= 4'hf;
      wait_reg <= '0;
      seen_reg <= 1'b0;
      s_rd_reg <= 1'b0;
      ad_oe_reg <= 1'b0;
      cbe_oe_reg <= 1'b0;
      frame_reg <= 1'b1;
      irdy_reg <= 1'b1;
      mctl_oe_reg <= 1'b0;
      trdy_reg <= 1'b1;
      devsel_reg <= 1'b1;
      tctl_oe_reg <= 1'b0;
      gnt_reg <= 1'b1;
      done_reg <= 1'b0;
      abort_reg <= 1'b0;
      par_reg <= 1'b0;
      par_oe_reg <= 1'b0;
      exp_reg <= 1'b0;
      chk_reg <= 1'b0;
      perr_reg <= 1'b0;
      frame_prev_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      h_reg <= h_next;
      s_reg <= s_next;
      idx_reg <= idx_next;
      ad_reg <= ad_next;
      rdata_reg <= rdata_next;
      cbe_reg <= cbe_next;
      wait_reg <= wait_next;
      seen_reg <= seen_next;
      s_rd_reg <= s_rd_next;
      ad_oe_reg <= ad_oe_next;
      cbe_oe_reg <= cbe_oe_next;
      frame_reg <= frame_next;
      irdy_reg <= irdy_next;
      mctl_oe_reg <= mctl_oe_next;
      trdy_reg <= trdy_next;
      devsel_reg <= devsel_next;
      tctl_oe_reg <= tctl_oe_next;
      gnt_reg <= gnt_next;
      done_reg <= done_next;
      abort_reg <= abort_next;
      par_reg <= ^{ad_reg, link.cbe_n};
      par_oe_reg <= ad_oe_reg;
      exp_reg <= ^{link.ad, link.cbe_n};
      chk_reg <= addr_seen || (h_xfer && !ad_oe_reg) || (s_xfer && !s_rd_reg);
      perr_reg <= chk_reg && (link.par != exp_reg);
      frame_prev_reg <= link.frame_n;
      busy_reg <= (h_next != H_IDLE);
    end
  end

  assign link.host_ad_o = ad_reg;
  assign link.host_ad_oe = ad_oe_reg;
  assign link.host_cbe_o = cbe_reg;
  assign link.host_cbe_oe = cbe_oe_reg;
  assign link.host_par_o = par_reg;
  assign link.host_par_oe = par_oe_reg;
  assign link.host_frame_o = frame_reg;
  assign link.host_frame_oe = mctl_oe_reg;
  assign link.host_irdy_o = irdy_reg;
  assign link.host_irdy_oe = mctl_oe_reg;
  assign link.host_trdy_o = trdy_reg;
  assign link.host_trdy_oe = tctl_oe_reg;
  assign link.host_devsel_o = devsel_reg;
  assign link.host_devsel_oe = tctl_oe_reg;
  assign link.host_stop_o = 1'b1;
  assign link.host_stop_oe = tctl_oe_reg;
  assign link.host_gnt_o = gnt_reg;
  assign hm_busy = busy_reg;
  assign hm_done = done_reg;
  assign hm_abort = abort_reg;
  assign hm_rdata = rdata_reg;
  assign par_err = perr_reg;
endmodule : host_pci_end

// ---- dv/pci_link_properties.sv ----
// assertions on the resolved wires of the pci link
`timescale 1ns/1ps
module pci_link_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // resolved wires
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  // enables
  input wire logic dev_ad_oe,
  input wire logic host_ad_oe,
  input wire logic dev_frame_oe,
  input wire logic dev_req_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // address falls in some target range
  wire logic hit = (ad - pci_pkg::NIC_BASE) < pci_pkg::NIC_SPAN || ad < pci_pkg::HOST_SPAN;
  wire logic drv = dev_ad_oe || host_ad_oe;
  // reset checks must run while reset is low, so no disable
  reset_float_a: assert property (disable iff (1'b0) !rstn |=>
    !dev_ad_oe && !host_ad_oe && !dev_frame_oe && !dev_req_oe) else $error("driven in reset");
  ad_owner_a: assert property (!(dev_ad_oe && host_ad_oe)) else $error("ad contention");
  even_parity_a: assert property (drv ##1 drv |->
    ^{$past(ad), $past(cbe_n), par} == 1'b0) else $error("odd parity");
  command_code_a: assert property ($fell(frame_n) |-> cbe_n == pci_pkg::CMD_MEM_READ
    || cbe_n == pci_pkg::CMD_MEM_WRITE) else $error("bad command");
  byte_enable_a: assert property (!irdy_n |-> cbe_n == pci_pkg::BE_ALL)
    else $error("bad byte enables");
  frame_irdy_a: assert property ($fell(frame_n) |=> !irdy_n) else $error("no irdy");
  last_phase_a: assert property ($rose(frame_n) |-> !irdy_n) else $error("late frame");
  word_move_a: assert property ($rose(irdy_n) && !$past(devsel_n) |-> !$past(trdy_n))
    else $error("irdy dropped unmoved");
  medium_decode_a: assert property ($fell(frame_n) && hit |-> ##2 !devsel_n && !trdy_n)
    else $error("devsel not at two");
  master_abort_a: assert property ($fell(frame_n) && !hit |-> ##[1:12] !dev_frame_oe)
    else $error("no abort");
endmodule : pci_link_properties

// ---- dv/pci_host_bus_interface_tb_top.sv ----
// bench: nic end and host end joined by one link
`timescale 1ns/1ps
module pci_host_bus_interface_tb_top;
  logic core_clk = 1'b0, rstn = 1'b0, dma_start = 1'b0, dma_tx = 1'b0;
  logic tx_pop = 1'b0, rx_push = 1'b0, hm_start = 1'b0;
  logic [31:0] dma_addr = 32'h0, rx_data = 32'h0, hm_addr = 32'h0, tx_data, hm_rdata;
  logic [15:0] dma_words = 16'h0;
  logic dma_busy, dma_abort, nic_perr, rx_full, hm_done, host_perr, tx_dv;
  int miscompares = 0;
  int num_checks = 0;
  logic [31:0] row_addr [3] = '{32'h0000_0010, 32'h0000_0200, 32'h0000_03f8};
  logic [15:0] row_words [3] = '{16'h1, 16'h4, 16'h2};
  always #50 core_clk = ~core_clk;
  pci_link_if link ();
  nic_pci_end #(.TX_WORDS(4), .RX_WORDS(4)) i_nic_pci_end (.core_clk(core_clk), .rstn(rstn),
    .link(link.dev), .dma_start(dma_start), .dma_tx(dma_tx), .dma_addr(dma_addr),
    .dma_words(dma_words), .dma_busy(dma_busy), .dma_abort(dma_abort), .par_err(nic_perr),
    .tx_pop(tx_pop), .tx_data(tx_data), .tx_dvalid(tx_dv), .rx_push(rx_push), .rx_data(rx_data),
    .rx_full(rx_full));
  host_pci_end i_host_pci_end (.core_clk(core_clk), .rstn(rstn), .link(link.host),
    .hm_start(hm_start), .hm_write(1'b0), .hm_addr(hm_addr), .hm_wdata(32'h0), .hm_busy(),
    .hm_done(hm_done), .hm_abort(), .hm_rdata(hm_rdata), .par_err(host_perr));
  pci_link_properties i_pci_link_properties (.core_clk(core_clk), .rstn(rstn), .ad(link.ad),
    .cbe_n(link.cbe_n), .par(link.par), .frame_n(link.frame_n), .irdy_n(link.irdy_n),
    .trdy_n(link.trdy_n), .devsel_n(link.devsel_n), .dev_ad_oe(link.dev_ad_oe),
    .host_ad_oe(link.host_ad_oe), .dev_frame_oe(link.dev_frame_oe), .dev_req_oe(link.dev_req_oe));
  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // good parity everywhere, so any flag is wrong
  always @(negedge core_clk) if (rstn === 1'b1 && (nic_perr | host_perr) !== 1'b0) begin
    chk("par_err", 32'h0, 32'h1);
  end
  task automatic waitfor(input int s);
    for (int n = 0; n < 200; n++) begin
      @(posedge core_clk);
      #1;
      if (s == 0 ? dma_busy === 1'b0 : s == 1 ? dma_abort === 1'b1 : hm_done === 1'b1) return;
    end
    miscompares++;
    end_sim;
  endtask : waitfor
  task automatic dma(input logic tx, input logic [31:0] a, input logic [15:0] w, input int s);
    @(posedge core_clk);
    dma_start <= 1'b1;
    dma_tx <= tx;
    dma_addr <= a;
    dma_words <= w;
    @(posedge core_clk);
    dma_start <= 1'b0;
    waitfor(s);
  endtask : dma
  task automatic fill(input int w, input logic [31:0] b);
    for (int i = 0; i < w; i++) begin
      @(posedge core_clk);
      rx_push <= 1'b1;
      rx_data <= b + 32'(i);
    end
    @(posedge core_clk);
    rx_push <= 1'b0;
  endtask : fill
  task automatic status(input logic [31:0] exp);
    @(posedge core_clk);
    hm_start <= 1'b1;
    hm_addr <= pci_pkg::NIC_BASE;
    @(posedge core_clk);
    hm_start <= 1'b0;
    waitfor(2);
    chk("status", exp, hm_rdata);
  endtask : status
  task automatic rst;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (pci_pkg::RESET_HOLD_CYCLES) @(posedge core_clk);
    rstn <= 1'b1;
  endtask : rst
  initial begin
    rst();
    for (int r = 0; r < 3; r++) begin
      fill(row_words[r], row_addr[r] ^ 32'ha5a5_0000);
      #1 chk("rx_full", {31'h0, row_words[r] == 16'h4}, {31'h0, rx_full});
      dma(1'b0, row_addr[r], row_words[r], 0);
      dma(1'b1, row_addr[r], row_words[r], 0);
      for (int i = 0; i < row_words[r]; i++) begin
        @(posedge core_clk) tx_pop <= 1'b1;
        @(posedge core_clk) tx_pop <= 1'b0;
        #1 chk("tx_data", (row_addr[r] ^ 32'ha5a5_0000) + 32'(i), tx_data);
        chk("tx_dvalid", 32'h1, {31'h0, tx_dv});
      end
    end
    fill(3, 32'h0);
    status(32'h0000_0003);
    dma(1'b1, 32'h4000_0000, 16'h1, 1);
    chk("dma_abort", 32'h1, {31'h0, dma_abort});
    waitfor(0);
    // mid-run reset must empty the fifo counts
    rst();
    status(32'h0000_0000);
    end_sim();
  end
endmodule : pci_host_bus_interface_tb_top
